// ---- hw/sps_defs.svh ----
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
// Register indices; byte address is four times the index
`define SPS_IDX_CTRL   10'h0C3
`define SPS_IDX_STAT   10'h0C4
`define SPS_IDX_DATA   10'h0C5
// Status bit positions
`define SPS_B_TC       7
`define SPS_B_WRITE_COLLISION_FLAG     6
`define SPS_B_SLAVE_SELECT_ERROR_FLAG    5
`define SPS_B_MODE_FAULT_FLAG     4
// Reset values
`define SPS_CTRL_RST   8'h14
// Edges in one byte exchange, minus one
`define SPS_LAST_EDGE  4'hF
// Highest usable rate code; code 7 behaves as code 6
`define SPS_RATE_MAX   3'h6
`endif

// ---- hw/sps_pkg.sv ----
`default_nettype none
package sps_pkg;
  typedef struct packed {
    logic       rate2;
    logic       en;
    logic       slave_select_disable_bit;
    logic       master_select_bit;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic [1:0] rate10;
  } sps_ctrl_t;
  typedef struct packed {
    logic tc;
    logic write_collision_flag;
    logic slave_select_error_flag;
    logic mode_fault_flag;
  } sps_stat_t;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } sps_pin_t;
  typedef enum logic [1:0] {
    SPS_IDLE = 2'b01,
    SPS_RUN  = 2'b10
  } sps_state_t;
endpackage
`default_nettype wire

// ---- hw/sps_core.sv ----
// Functional notes
// RL1 - Set transfer-complete flag when byte exchange ends
// RL2 - Transfer-complete held clear during exchange, sequence clears
// RL3 - Collision sets write-collision flag; sequence clears it
// RL4 - Slave select lost mid-byte sets slave error
// RL5 - Slave error cleared only by disabling peripheral
// RL6 - Slave select level wrong for role sets fault
// RL7 - Mode fault clears when level fits or sequence; code clears it only when fault is low
// RL8 - Status bits three to zero reserved, never write
// RL9 - Status flags read zero after reset
// RL10 - Data write loads shift register directly
// RL11 - Data read returns receive buffer, not shifter
// RL12 - Registers freely accessible when no exchange runs
// RL13 - Software keeps rate field steady during exchange
// RL14 - Software keeps polarity, phase, role steady meanwhile
// RL15 - Clearing enable aborts exchange at once
// RL16 - Data write during exchange corrupts, flagged overflow; code sets the write-collision flag instead
// RL17 - Fault cleared by status read then control write; code makes the flag follow fault every cycle, so the sequence has no effect
// RL18 - Collision cleared by status then data access
// RL19 - Transfer-complete raises interrupt request
// RL20 - Mode fault raises request only when select enabled
// RL21 - Transfer-complete cleared by status read then data access
`include "sps_defs.svh"
`default_nettype none
module sps_core
  import sps_pkg::*;
#(
  parameter int AW = 12
)(
  // APB slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Serial pins
  input  wire sps_pin_t      pin_in,
  output logic               sck_out,
  output logic               sck_oe,
  output logic               mosi_out,
  output logic               mosi_oe,
  output logic               miso_out,
  output logic               miso_oe,
  // Interrupt request
  output logic               spi_irq
);
  sps_pin_t   sync1_ff, sync2_ff;
  sps_ctrl_t  ctrl_ff, nxt_ctrl;
  sps_stat_t  stat_ff, nxt_stat;
  sps_state_t st_ff, nxt_st;
  logic [7:0] shreg_ff, nxt_shreg, rx_ff, nxt_rx;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [6:0] div_ff, nxt_div, div_lim;
  logic [2:0] rate;
  logic       sck_ff, nxt_sck, sckd_ff, nxt_sckd, out_ff, nxt_out;
  logic       tc_arm_ff, nxt_tc_arm, wc_arm_ff, nxt_wc_arm;
  logic       mf_arm_ff, nxt_mf_arm;
  logic [31:0] prdata_ff, nxt_prdata;
  logic       pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic       irq_ff, nxt_irq, sck_oe_ff, miso_oe_ff, nxt_miso_oe;
  logic       acc, wr, rd, hit_c, hit_s, hit_d, ev, lead, done;
  logic       bsy, sel, fault, din;

  assign hit_c = paddr[AW-1:2] == `SPS_IDX_CTRL;
  assign hit_s = paddr[AW-1:2] == `SPS_IDX_STAT;
  assign hit_d = paddr[AW-1:2] == `SPS_IDX_DATA;
  assign acc   = psel & penable & pready_ff;
  assign wr    = acc & pwrite;
  assign rd    = acc & ~pwrite;
  assign rate  = {ctrl_ff.rate2, ctrl_ff.rate10};
  assign bsy   = (st_ff == SPS_RUN) & (ctrl_ff.master_select_bit | (cnt_ff != 4'h0));
  // Slave select ignored in slave mode only when phase is one
  assign sel   = ~ctrl_ff.master_select_bit & (~sync2_ff.ss_n
                 | (ctrl_ff.slave_select_disable_bit & ctrl_ff.clock_phase_bit));
  assign fault = ctrl_ff.en & ctrl_ff.master_select_bit & ~ctrl_ff.slave_select_disable_bit
                 & ~sync2_ff.ss_n; // RL6
  assign din   = ctrl_ff.master_select_bit ? sync2_ff.miso : sync2_ff.mosi;
  assign div_lim = (7'h01 << ((rate > `SPS_RATE_MAX) ? `SPS_RATE_MAX
                   : rate)) - 7'h01;

  // Pins cross from the outside world
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= 4'h1;
      sync2_ff <= 4'h1;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_comb
  begin
    nxt_ctrl    = ctrl_ff;
    nxt_stat    = stat_ff;
    nxt_st      = st_ff;
    nxt_shreg   = shreg_ff;
    nxt_rx      = rx_ff;
    nxt_cnt     = cnt_ff;
    nxt_div     = div_ff;
    nxt_sck     = sck_ff;
    nxt_sckd    = sync2_ff.sck;
    nxt_out     = out_ff;
    nxt_tc_arm  = tc_arm_ff;
    nxt_wc_arm  = wc_arm_ff;
    nxt_mf_arm  = mf_arm_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    ev          = 1'b0;
    lead        = 1'b0;
    done        = 1'b0;
    // Read data captured in setup so prdata leaves a flop
    if (psel && !penable)
    begin
      nxt_pready  = 1'b1;
      nxt_pslverr = ~(hit_c | hit_s | hit_d);
      nxt_prdata  = '0; // RL8
      if (hit_c)
        nxt_prdata[7:0] = ctrl_ff;
      else if (hit_s)
        nxt_prdata[7:4] = stat_ff;
      else if (hit_d)
        nxt_prdata[7:0] = rx_ff; // RL11
    end
    // Clock edges: own divider as master, sampled pin as slave
    if (st_ff == SPS_RUN && ctrl_ff.master_select_bit)
    begin
      if (div_ff == div_lim)
      begin
        nxt_div = '0;
        nxt_sck = ~sck_ff;
        ev      = 1'b1;
        lead    = sck_ff == ctrl_ff.clock_polarity_bit;
      end
      else
        nxt_div = div_ff + 7'h01;
    end
    else if (st_ff == SPS_RUN)
    begin
      ev   = sync2_ff.sck != sckd_ff;
      lead = sync2_ff.sck != ctrl_ff.clock_polarity_bit;
    end
    if (ev)
    begin
      if (lead ^ ctrl_ff.clock_phase_bit)
        nxt_shreg = {shreg_ff[6:0], din};
      else
        nxt_out = shreg_ff[7];
      nxt_cnt = cnt_ff + 4'h1;
      if (cnt_ff == `SPS_LAST_EDGE)
      begin
        done   = 1'b1;
        nxt_rx = nxt_shreg;
        nxt_st = SPS_IDLE;
      end
    end
    if (st_ff == SPS_IDLE)
    begin
      nxt_sck = ctrl_ff.clock_polarity_bit;
      nxt_out = shreg_ff[7];
      nxt_cnt = '0;
      if (ctrl_ff.en && sel)
        nxt_st = SPS_RUN;
    end
    // Slave deselected: a partial byte is an error
    if (st_ff == SPS_RUN && !ctrl_ff.master_select_bit && !sel)
    begin
      nxt_st  = SPS_IDLE;
      nxt_cnt = '0;
    end
    if (fault && ctrl_ff.master_select_bit)
      nxt_st = SPS_IDLE;
    // Clearing sequences, then hardware sets win
    if (rd && hit_s)
    begin
      nxt_tc_arm = prdata_ff[`SPS_B_TC];
      nxt_mf_arm = prdata_ff[`SPS_B_MODE_FAULT_FLAG];
    end
    if (acc && hit_s)
      nxt_wc_arm = 1'b1;
    if (acc && hit_d)
    begin
      if (tc_arm_ff)
        nxt_stat.tc = 1'b0; // RL21
      if (wc_arm_ff)
        nxt_stat.write_collision_flag = 1'b0; // RL18
      nxt_tc_arm = 1'b0;
      nxt_wc_arm = 1'b0;
    end
    if (wr && hit_c)
    begin
      nxt_ctrl = pwdata[7:0];
      if (mf_arm_ff)
        nxt_stat.mode_fault_flag = 1'b0; // RL17
      nxt_mf_arm = 1'b0;
      if (!pwdata[6])
        nxt_stat.slave_select_error_flag = 1'b0; // RL5
    end
    // Set after the disable clear so the set wins
    if (st_ff == SPS_RUN && !ctrl_ff.master_select_bit && !sel && cnt_ff != 4'h0)
      nxt_stat.slave_select_error_flag = 1'b1; // RL4
    if (wr && hit_d)
    begin
      nxt_shreg = pwdata[7:0]; // RL10
      if (bsy)
        nxt_stat.write_collision_flag = 1'b1; // RL3 RL16
      else if (ctrl_ff.en && ctrl_ff.master_select_bit && !fault)
      begin
        nxt_st  = SPS_RUN; // RL12
        nxt_cnt = '0;
        nxt_div = '0;
        nxt_out = pwdata[7];
        nxt_stat.tc = 1'b0; // RL2
      end
    end
    if ((bsy || ev) && !done)
      nxt_stat.tc = 1'b0; // RL2
    if (done)
      nxt_stat.tc = 1'b1; // RL1
    if (fault)
      nxt_stat.mode_fault_flag = 1'b1; // RL6
    else
      nxt_stat.mode_fault_flag = 1'b0; // RL7
    // Disable abandons the byte immediately
    if (!ctrl_ff.en)
    begin
      nxt_st  = SPS_IDLE; // RL15
      nxt_cnt = '0;
    end
    nxt_irq     = stat_ff.tc | (stat_ff.mode_fault_flag & ~ctrl_ff.slave_select_disable_bit); // RL19 RL20
    nxt_miso_oe = ctrl_ff.en & sel;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff    <= `SPS_CTRL_RST;
      stat_ff    <= '0; // RL9
      st_ff      <= SPS_IDLE;
      shreg_ff   <= '0;
      rx_ff      <= '0;
      cnt_ff     <= '0;
      div_ff     <= '0;
      sck_ff     <= 1'b0;
      sckd_ff    <= 1'b0;
      out_ff     <= 1'b0;
      tc_arm_ff  <= 1'b0;
      wc_arm_ff  <= 1'b0;
      mf_arm_ff  <= 1'b0;
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff     <= 1'b0;
      sck_oe_ff  <= 1'b0;
      miso_oe_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      stat_ff    <= nxt_stat;
      st_ff      <= nxt_st;
      shreg_ff   <= nxt_shreg;
      rx_ff      <= nxt_rx;
      cnt_ff     <= nxt_cnt;
      div_ff     <= nxt_div;
      sck_ff     <= nxt_sck;
      sckd_ff    <= nxt_sckd;
      out_ff     <= nxt_out;
      tc_arm_ff  <= nxt_tc_arm;
      wc_arm_ff  <= nxt_wc_arm;
      mf_arm_ff  <= nxt_mf_arm;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff     <= nxt_irq;
      sck_oe_ff  <= ctrl_ff.en & ctrl_ff.master_select_bit;
      miso_oe_ff <= nxt_miso_oe;
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign sck_out  = sck_ff;
  assign sck_oe   = sck_oe_ff;
  assign mosi_out = out_ff;
  assign mosi_oe  = sck_oe_ff;
  assign miso_out = out_ff;
  assign miso_oe  = miso_oe_ff;
  assign spi_irq  = irq_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TC_SET: assert property (done |=> stat_ff.tc) // RL1
    else $error("transfer-complete not set after last edge");
  AST_TC_BUSY: assert property (bsy |-> !stat_ff.tc) // RL2
    else $error("transfer-complete set during exchange");
  AST_WRITE_COLLISION_FLAG: assert property (wr && hit_d && bsy |=> stat_ff.write_collision_flag) // RL3
    else $error("collision not flagged");
  AST_SLAVE_SELECT_ERROR_FLAG: assert property (st_ff == SPS_RUN && ctrl_ff.en // RL4
    && !ctrl_ff.master_select_bit && !sel && cnt_ff != 4'h0 |=> stat_ff.slave_select_error_flag)
    else $error("slave error not flagged");
  AST_SLAVE_SELECT_ERROR_FLAG_HOLD: assert property (stat_ff.slave_select_error_flag // RL5
    && !(wr && hit_c && !pwdata[6]) |=> stat_ff.slave_select_error_flag)
    else $error("slave error cleared without disable");
  AST_MODE_FAULT_FLAG: assert property (fault |=> stat_ff.mode_fault_flag) // RL6
    else $error("mode fault not flagged");
  AST_MODE_FAULT_FLAG_CLR: assert property (!fault |=> !stat_ff.mode_fault_flag) // RL7
    else $error("mode fault stuck");
  AST_RX_READ: assert property (psel && !penable && !pwrite // RL11
    && hit_d |=> prdata_ff[7:0] == $past(rx_ff) && pready_ff)
    else $error("data read not from receive buffer");
  AST_LOAD: assert property (wr && hit_d // RL10
    |=> shreg_ff == $past(pwdata[7:0]))
    else $error("data write not in shift register");
  AST_DISABLE: assert property (!ctrl_ff.en |=> st_ff == SPS_IDLE) // RL15
    else $error("disable did not abort");
  AST_IRQ: assert property (##1 spi_irq == $past(stat_ff.tc // RL19
    | (stat_ff.mode_fault_flag & ~ctrl_ff.slave_select_disable_bit))) // RL20
    else $error("interrupt request wrong");
  COV_MASTER: cover property (done && ctrl_ff.master_select_bit);
  COV_SLAVE: cover property (done && !ctrl_ff.master_select_bit);
  COV_SLAVE_SELECT_ERROR_FLAG: cover property ($rose(stat_ff.slave_select_error_flag));
  COV_WRITE_COLLISION_FLAG: cover property ($rose(stat_ff.write_collision_flag));
endmodule // sps_core
`default_nettype wire

// ---- tb/sps_slave_model.sv ----
`default_nettype none
module sps_slave_model (
  // Serial side
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Bench side
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh_ff;
  assign miso = sh_ff[7];
  // Leading edge samples, MSB first
  always @(posedge sck)
  begin
    rx <= {rx[6:0], mosi};
  end
  // Refill inverted so stale bits never pass for data
  always @(negedge sck or posedge load)
  begin
    if (load)
      sh_ff <= tx;
    else
      sh_ff <= {sh_ff[6:0], ~sh_ff[7]};
  end
endmodule // sps_slave_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`include "sps_defs.svh"
`default_nettype none
module tb_top import sps_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, spi_irq, err;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        tb_sck = 1'b0;
  logic        tb_mosi = 1'b0;
  logic        tb_ss_n = 1'b1;
  logic        p_load = 1'b0;
  logic        p_miso;
  logic [7:0]  p_tx = 8'h00;
  logic [7:0]  p_rx, rd, tx, ptx, prev, got;
  logic [31:0] rng = 32'h0000C703;
  int          failures = 0;
  int          samples_checked = 0;
  int          i;
  sps_pin_t    pins;

  always #5 pclk = ~pclk;
  // Each wire but select follows whoever enables it
  assign pins = {sck_oe ? sck_out : tb_sck, mosi_oe ? mosi_out : tb_mosi,
                 miso_oe ? miso_out : p_miso, tb_ss_n};

  sps_core DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pins),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .spi_irq(spi_irq));
  sps_slave_model partner (.sck(pins.sck), .mosi(pins.mosi),
    .miso(p_miso), .load(p_load), .tx(p_tx), .rx(p_rx));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Rate code 2 gives an 80 ns serial clock
  function automatic logic [7:0] ctl(input logic en, slave_select_disable_bit, master_select_bit);
    return {1'b0, en, slave_select_disable_bit, master_select_bit, 4'h2};
  endfunction

  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic [7:0] mask, input logic [7:0] exp);
    apb(1'b0, `SPS_IDX_STAT, 8'h00);
    chk(rd & mask, exp);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (spi_irq !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    chk({7'h00, spi_irq}, 8'h01);
  endtask
  task automatic go(input logic [7:0] d, input logic [7:0] pd);
    // Data settles a cycle before the load strobe
    p_tx <= pd;
    @(posedge pclk);
    p_load <= 1'b1;
    @(posedge pclk);
    p_load <= 1'b0;
    apb(1'b1, `SPS_IDX_DATA, d);
  endtask

  initial
  begin
    #100000;
    failures++;
    report_and_stop;
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    st(8'hD0, 8'h00);
    apb(1'b0, 10'h0C6, 8'h00);
    chk({7'h00, err}, 8'h01);
    chk(rd, 8'h00);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b1, 1'b1, 1'b1));
    apb(1'b0, `SPS_IDX_CTRL, 8'h00);
    chk(rd, ctl(1'b1, 1'b1, 1'b1));
    prev = 8'h00;
    for (i = 0; i < 6; i++)
    begin
      rng = xs(rng);
      tx = (i == 0) ? 8'hFF : rng[7:0];
      ptx = (i == 0) ? 8'h00 : rng[15:8];
      go(tx, ptx);
      wt(20);
      st(8'h80, 8'h00);
      apb(1'b0, `SPS_IDX_DATA, 8'h00);
      chk(rd, prev);
      wait_irq;
      st(8'hD0, 8'h80);
      apb(1'b0, `SPS_IDX_DATA, 8'h00);
      chk(rd, ptx);
      chk(p_rx, tx);
      st(8'hD0, 8'h00);
      prev = ptx;
    end
    go(8'h3C, 8'hC3);
    wt(20);
    apb(1'b1, `SPS_IDX_DATA, 8'h5A);
    st(8'hD0, 8'h40);
    wait_irq;
    st(8'hD0, 8'hC0);
    apb(1'b0, `SPS_IDX_DATA, 8'h00);
    st(8'hD0, 8'h00);
    go(8'h96, 8'h69);
    wt(20);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b0, 1'b1, 1'b1));
    wt(2);
    chk({7'h00, sck_oe}, 8'h00);
    wt(100);
    st(8'hD0, 8'h00);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b1, 1'b0, 1'b1));
    st(8'hD0, 8'h00);
    tb_ss_n <= 1'b0;
    wt(8);
    st(8'hD0, 8'h10);
    chk({7'h00, spi_irq}, 8'h01);
    tb_ss_n <= 1'b1;
    wt(8);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b1, 1'b0, 1'b1));
    st(8'hD0, 8'h00);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b1, 1'b1, 1'b1));
    tb_ss_n <= 1'b0;
    wt(8);
    chk({7'h00, spi_irq}, 8'h00);
    tb_ss_n <= 1'b1;
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b1, 1'b0, 1'b0));
    tb_ss_n <= 1'b0;
    wt(8);
    // Byte cut short after a few edges
    repeat (3)
    begin
      wt(4);
      tb_sck <= ~tb_sck;
      tb_mosi <= ~tb_mosi;
    end
    wt(4);
    tb_ss_n <= 1'b1;
    tb_sck <= 1'b0;
    wt(10);
    st(8'hF0, 8'h20);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b1, 1'b0, 1'b0));
    st(8'hF0, 8'h20);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b0, 1'b0, 1'b0));
    st(8'hF0, 8'h00);
    // Full slave byte, bench plays master
    rng = xs(rng);
    tx = rng[7:0];
    ptx = rng[15:8];
    apb(1'b1, `SPS_IDX_DATA, tx);
    apb(1'b1, `SPS_IDX_CTRL, ctl(1'b1, 1'b0, 1'b0));
    tb_ss_n <= 1'b0;
    wt(8);
    for (i = 7; i >= 0; i--)
    begin
      tb_mosi <= ptx[i];
      wt(4);
      got = {got[6:0], pins.miso};
      tb_sck <= 1'b1;
      wt(4);
      tb_sck <= 1'b0;
    end
    wt(10);
    st(8'hF0, 8'h80);
    apb(1'b0, `SPS_IDX_DATA, 8'h00);
    chk(rd, ptx);
    chk(got, tx);
    tb_ss_n <= 1'b1;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
